// File: cma_pkg.sv
// Functional notes
// - return stack holds sixteen entries of fifteen bits for calls, returns, interrupts.
// - overflow or underflow sets its flag; with option enabled triggers software reset.
// - interrupt entry copies status, working, bank, latch-high and pointer registers to shadows; interrupt return restores them.
// - two sixteen-bit pointers reach every file register and program memory.
// - pointer high byte bit 7 set selects program memory for indirect reads.
// - indirect read of program memory returns only the low eight word bits.
// - indirect writes aimed at program memory never change program memory.
// - indirect program memory reads take one additional cycle to fetch.
// - program counter is fifteen bits, spanning 32K words of fourteen bits.
// - program addresses past 0FFFh wrap into the 4096-word array.
// - execution starts at 0000h after reset; accepted interrupt vectors to 0004h.
// - data memory is thirty-two banks of 128 bytes each.
// - bank holds 12 core, 20 special, 80 general, 16 shared common bytes.
// - direct accesses use the bank last written to bank select.
// - reads of unimplemented data locations return zero.
// - data address is twelve bits: five bank bits, seven offset bits.
// - core registers sit at first twelve offsets of every bank.
// - pointers give a linear contiguous view of general RAM across banks.
package cma_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 15;
  localparam int PROG_AW = 12;
  localparam int PROG_DW = 14;
  localparam int STK_DEPTH = 16;
  localparam int PROG_SEL_BIT = 15;
  // ----------------------------------------------------------------
  // vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] IRQ_VEC = 15'h0004;
  localparam logic [7:0] REG_RST = 8'h00;
  // ----------------------------------------------------------------
  // core register offsets and bank layout
  // ----------------------------------------------------------------
  localparam logic [6:0] OFF_INDIRECT_DATA_0 = 7'h00;
  localparam logic [6:0] OFF_INDIRECT_DATA_1 = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR0L = 7'h04;
  localparam logic [6:0] OFF_PTR0H = 7'h05;
  localparam logic [6:0] OFF_PTR1L = 7'h06;
  localparam logic [6:0] OFF_PTR1H = 7'h07;
  localparam logic [6:0] OFF_BANK = 7'h08;
  localparam logic [6:0] OFF_WORKING_REG = 7'h09;
  localparam logic [6:0] OFF_PROG_COUNTER_LATCH_HIGH = 7'h0A;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
  localparam logic [6:0] NUM_CORE = 7'h0C;
  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam logic [6:0] COMMON_BASE = 7'h70;
  localparam logic [4:0] COMMON_BANK = 5'h00;
  localparam logic [12:0] GPR_PER_BANK = 13'h0050;
  localparam logic [12:0] LIN_LIMIT = 13'h0A00;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_NEXT = 3'b001, OP_GOTO = 3'b010, OP_CALL = 3'b011,
    OP_RETURN = 3'b100, OP_RETFIE = 3'b101, OP_BRW = 3'b110
  } cma_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ISSUE = 3'b001, ST_EXTRA = 3'b010,
    ST_CAPT = 3'b011, ST_DONE = 3'b100
  } cma_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cma_dmem_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_reg;
    logic [4:0] bank;
    logic [7:0] prog_counter_latch_high;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
  } cma_ctx_t;
endpackage

// File: cma_ret_stack.sv
`timescale 1ns/100ps
module cma_ret_stack
  import cma_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH,
  parameter int WIDTH = PC_W
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  // push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] topData,
  // status
  output logic overflow,
  output logic underflow,
  output logic [$clog2(DEPTH+1)-1:0] depth
);
  localparam int CW = $clog2(DEPTH+1);
  localparam int IW = $clog2(DEPTH);

  logic [WIDTH-1:0] memFf [DEPTH];
  logic [CW-1:0] cntFf;

  // occupancy decode
  wire full = (cntFf == CW'(DEPTH));
  wire empty = (cntFf == '0);
  wire [CW-1:0] topIdx = cntFf - CW'(1);
  wire doPush = push & !full;
  wire doPop = pop & !empty;

  assign overflow = push & full;
  assign underflow = pop & empty;
  assign topData = empty ? '0 : memFf[topIdx[IW-1:0]];
  assign depth = cntFf;

  // entry storage, sixteen by fifteen bits
  always_ff @(posedge clk_sys)
  begin
    if (doPush)
      memFf[cntFf[IW-1:0]] <= pushData;
  end

  // occupancy counter
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      cntFf <= '0;
    else if (clear)
      cntFf <= '0;
    else if (doPush)
      cntFf <= cntFf + CW'(1);
    else if (doPop)
      cntFf <= cntFf - CW'(1);
  end
endmodule

// File: cma_addr_map.sv
`timescale 1ns/100ps
module cma_addr_map
  import cma_pkg::*;
(
  // access source
  input wire logic viaPtr,
  input wire logic [15:0] ptr,
  input wire logic [4:0] bank,
  input wire logic [6:0] off,
  // resolved target
  output logic toProg,
  output logic [PROG_AW-1:0] progAddr,
  output logic [11:0] physAddr,
  output logic coreHit,
  output logic [6:0] coreOff,
  output logic unimpl
);
  // pointer regions: banked, linear general RAM
  wire isTrad = viaPtr & (ptr[15:12] == 4'h0);
  wire [12:0] linOff = ptr[12:0];
  wire isLin = viaPtr & (ptr[15:13] == 3'b001) & (linOff < LIN_LIMIT);
  wire [12:0] linBank = linOff / GPR_PER_BANK;
  wire [12:0] linIdx = linOff % GPR_PER_BANK;
  wire [6:0] linInBank = GPR_BASE + linIdx[6:0];

  // bank and offset selection
  wire [4:0] selBank = !viaPtr ? bank : (isTrad ? ptr[11:7] : linBank[4:0]);
  wire [6:0] selOff = !viaPtr ? off : (isTrad ? ptr[6:0] : linInBank);

  assign toProg = viaPtr & ptr[PROG_SEL_BIT];
  assign progAddr = ptr[PROG_AW-1:0];
  assign unimpl = viaPtr & !toProg & !isTrad & !isLin;
  assign coreHit = !toProg & !unimpl & (selOff < NUM_CORE);
  assign coreOff = selOff;
  // common RAM folds onto one bank, 32 x 128 bytes otherwise
  assign physAddr = (selOff >= COMMON_BASE) ? {COMMON_BANK, selOff}
                                            : {selBank, selOff};
endmodule

// File: cma_core.sv
`timescale 1ns/100ps
module cma_core
  import cma_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // configuration
  input wire logic stkResetEn,
  input wire logic stkFlagClr,
  // instruction flow
  input wire cma_op_t op,
  input wire logic [10:0] opLit,
  input wire logic irqAccept,
  // file register port
  input wire logic fileReq,
  input wire logic fileWe,
  input wire logic [6:0] fileAddr,
  input wire logic [7:0] fileWdata,
  output logic fileReady,
  output logic fileAck,
  output logic [7:0] fileRdata,
  // program memory
  output logic [PROG_AW-1:0] fetchAddr,
  output logic [PROG_AW-1:0] progAddr,
  output logic progRe,
  input wire logic [PROG_DW-1:0] progRdata,
  // data memory
  output cma_dmem_t dmem,
  input wire logic [7:0] dmemRdata,
  // status
  output logic [PC_W-1:0] pcOut,
  output logic [7:0] wregOut,
  output logic [7:0] statusOut,
  output logic [4:0] bankOut,
  output logic stkOvfFlag,
  output logic stkUnfFlag,
  output logic softResetReq,
  output logic [4:0] stackDepth
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PC_W-1:0] pcFf, nxt_pc;
  logic [7:0] statusFf, wregFf, pclathFf, intconFf;
  logic [4:0] bankFf;
  logic [15:0] ptr0Ff, ptr1Ff;
  cma_ctx_t shadowFf, nxt_ctx;
  logic stkOvfFf, stkUnfFf, softRstFf;
  cma_state_t stateFf, nxt_state;
  logic reqWeFf, reqProgFf, reqUnimplFf, progReFf;
  logic [PROG_AW-1:0] progAddrFf;
  logic [7:0] rdataFf, nxt_rdata;
  cma_dmem_t dmemFf, nxt_dmem;
  logic stkPush, stkPop;
  logic [PC_W-1:0] stkTop;
  logic stkOvfEv, stkUnfEv;
  logic [7:0] coreRdata;

  // program counter increment with natural 15-bit wrap
  function automatic logic [PC_W-1:0] incPc(input logic [PC_W-1:0] pc);
    incPc = pc + PC_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire idle = (stateFf == ST_IDLE);
  wire takeReq = fileReq & idle & !softRstFf;
  wire isIndf = (fileAddr == OFF_INDIRECT_DATA_0) | (fileAddr == OFF_INDIRECT_DATA_1);
  wire [15:0] selPtr = fileAddr[0] ? ptr1Ff : ptr0Ff;
  wire mapProg, mapCore, mapUnimpl;
  wire [6:0] mapOff;
  wire [11:0] mapPhys;
  wire [PROG_AW-1:0] mapProgAddr;
  wire coreWe = takeReq & mapCore & fileWe;
  wire selfIndf = mapOff < OFF_PCL;
  wire [7:0] progLow = progRdata[7:0];
  wire [7:0] shadowWreg = shadowFf.working_reg;
  wire [4:0] shadowBank = shadowFf.bank;

  cma_addr_map u_map (
    .viaPtr(isIndf),
    .ptr(selPtr),
    .bank(bankFf),
    .off(fileAddr),
    .toProg(mapProg),
    .progAddr(mapProgAddr),
    .physAddr(mapPhys),
    .coreHit(mapCore),
    .coreOff(mapOff),
    .unimpl(mapUnimpl)
  );

  cma_ret_stack u_stack (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(softRstFf),
    .push(stkPush),
    .pop(stkPop),
    .pushData(irqAccept ? pcFf : incPc(pcFf)),
    .topData(stkTop),
    .overflow(stkOvfEv),
    .underflow(stkUnfEv),
    .depth(stackDepth)
  );

  // ----------------------------------------------------------------
  // program counter and stack control
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_pc = pcFf;
    stkPush = 1'b0;
    stkPop = 1'b0;
    if (softRstFf)
      nxt_pc = RESET_VEC;
    else if (irqAccept)
    begin
      stkPush = 1'b1;
      nxt_pc = IRQ_VEC;
    end
    else
    begin
      case (op)
        OP_NEXT: nxt_pc = incPc(pcFf);
        OP_GOTO: nxt_pc = {pclathFf[6:3], opLit};
        OP_CALL:
        begin
          stkPush = 1'b1;
          nxt_pc = {pclathFf[6:3], opLit};
        end
        OP_RETURN, OP_RETFIE:
        begin
          stkPop = 1'b1;
          nxt_pc = stkTop;
        end
        OP_BRW: nxt_pc = incPc(pcFf) + {7'h00, wregFf};
        default: nxt_pc = pcFf;
      endcase
      if (coreWe && mapOff == OFF_PCL)
        nxt_pc = {pclathFf[6:0], fileWdata};
    end
  end

  // ----------------------------------------------------------------
  // core registers, shadow restore and software writes
  // ----------------------------------------------------------------
  wire restore = (op == OP_RETFIE) & !irqAccept;
  always_comb
  begin
    nxt_ctx = '{statusFf, wregFf, bankFf, pclathFf, ptr0Ff, ptr1Ff};
    if (coreWe)
    begin
      case (mapOff)
        OFF_STATUS: nxt_ctx.status = fileWdata;
        OFF_PTR0L: nxt_ctx.ptr0[7:0] = fileWdata;
        OFF_PTR0H: nxt_ctx.ptr0[15:8] = fileWdata;
        OFF_PTR1L: nxt_ctx.ptr1[7:0] = fileWdata;
        OFF_PTR1H: nxt_ctx.ptr1[15:8] = fileWdata;
        OFF_BANK: nxt_ctx.bank = fileWdata[4:0];
        OFF_WORKING_REG: nxt_ctx.working_reg = fileWdata;
        OFF_PROG_COUNTER_LATCH_HIGH: nxt_ctx.prog_counter_latch_high = {1'b0, fileWdata[6:0]};
        default: nxt_ctx = nxt_ctx;
      endcase
    end
    if (restore)
      nxt_ctx = shadowFf;
  end

  // core register read mux, same in every bank
  always_comb
  begin
    case (mapOff)
      OFF_PCL: coreRdata = pcFf[7:0];
      OFF_STATUS: coreRdata = statusFf;
      OFF_PTR0L: coreRdata = ptr0Ff[7:0];
      OFF_PTR0H: coreRdata = ptr0Ff[15:8];
      OFF_PTR1L: coreRdata = ptr1Ff[7:0];
      OFF_PTR1H: coreRdata = ptr1Ff[15:8];
      OFF_BANK: coreRdata = {3'b000, bankFf};
      OFF_WORKING_REG: coreRdata = wregFf;
      OFF_PROG_COUNTER_LATCH_HIGH: coreRdata = pclathFf;
      OFF_INTERRUPT_CONTROL: coreRdata = intconFf;
      default: coreRdata = REG_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = stateFf;
    nxt_rdata = rdataFf;
    nxt_dmem = dmemFf;
    case (stateFf)
      ST_IDLE:
        if (takeReq)
        begin
          if (mapCore)
          begin
            nxt_state = ST_DONE;
            if (!fileWe)
              nxt_rdata = selfIndf ? REG_RST : coreRdata;
          end
          else if (mapProg && fileWe)
            nxt_state = ST_DONE;
          else
          begin
            nxt_state = ST_ISSUE;
            nxt_dmem.addr = mapPhys;
            nxt_dmem.wdata = fileWdata;
            nxt_dmem.we = fileWe & !mapUnimpl;
            nxt_dmem.re = !fileWe & !mapUnimpl & !mapProg;
          end
        end
      ST_ISSUE:
      begin
        nxt_dmem.we = 1'b0;
        nxt_dmem.re = 1'b0;
        if (reqWeFf)
          nxt_state = ST_DONE;
        else if (reqProgFf)
          nxt_state = ST_EXTRA;
        else
          nxt_state = ST_CAPT;
      end
      ST_EXTRA: nxt_state = ST_CAPT;
      ST_CAPT:
      begin
        nxt_state = ST_DONE;
        if (reqUnimplFf)
          nxt_rdata = REG_RST;
        else if (reqProgFf)
          nxt_rdata = progLow;
        else
          nxt_rdata = dmemRdata;
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // program counter and core registers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pcFf <= RESET_VEC;
      {statusFf, wregFf, bankFf, pclathFf, ptr0Ff, ptr1Ff} <= '0;
      intconFf <= REG_RST;
    end
    else if (softRstFf)
    begin
      pcFf <= RESET_VEC;
      {statusFf, wregFf, bankFf, pclathFf, ptr0Ff, ptr1Ff} <= '0;
      intconFf <= REG_RST;
    end
    else
    begin
      pcFf <= nxt_pc;
      {statusFf, wregFf, bankFf, pclathFf, ptr0Ff, ptr1Ff} <= nxt_ctx;
      if (coreWe && mapOff == OFF_INTERRUPT_CONTROL)
        intconFf <= fileWdata;
    end
  end

  // shadow copy on interrupt entry
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      shadowFf <= '0;
    else if (irqAccept && !softRstFf)
      shadowFf <= '{statusFf, wregFf, bankFf, pclathFf, ptr0Ff, ptr1Ff};
  end

  // stack flags, cleared only by stkFlagClr or power-on reset; software reset keeps them
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      stkOvfFf <= 1'b0;
      stkUnfFf <= 1'b0;
      softRstFf <= 1'b0;
    end
    else
    begin
      stkOvfFf <= stkOvfEv | (stkOvfFf & !stkFlagClr);
      stkUnfFf <= stkUnfEv | (stkUnfFf & !stkFlagClr);
      softRstFf <= (stkOvfEv | stkUnfEv) & stkResetEn;
    end
  end

  // sequencer and memory strobes
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      stateFf <= ST_IDLE;
      dmemFf <= '0;
      rdataFf <= REG_RST;
      {reqWeFf, reqProgFf, reqUnimplFf, progReFf} <= 4'h0;
      progAddrFf <= '0;
    end
    else if (softRstFf)
    begin
      stateFf <= ST_IDLE;
      dmemFf <= '0;
      progReFf <= 1'b0;
    end
    else
    begin
      stateFf <= nxt_state;
      dmemFf <= nxt_dmem;
      rdataFf <= nxt_rdata;
      progReFf <= takeReq & mapProg & !fileWe;
      if (takeReq)
      begin
        {reqWeFf, reqProgFf, reqUnimplFf} <= {fileWe, mapProg, mapUnimpl};
        progAddrFf <= mapProgAddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fileReady = idle & !softRstFf;
  assign fileAck = (stateFf == ST_DONE);
  assign fileRdata = rdataFf;
  assign fetchAddr = pcFf[PROG_AW-1:0];
  assign progAddr = progAddrFf;
  assign progRe = progReFf;
  assign dmem = dmemFf;
  assign pcOut = pcFf;
  assign wregOut = wregFf;
  assign statusOut = statusFf;
  assign bankOut = bankFf;
  assign stkOvfFlag = stkOvfFf;
  assign stkUnfFlag = stkUnfFf;
  assign softResetReq = softRstFf;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_irq_vector;
    irqAccept && !softRstFf |=> pcFf == IRQ_VEC;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("irq vector missed");

  property p_soft_vector;
    softRstFf |=> pcFf == RESET_VEC && stateFf == ST_IDLE;
  endproperty
  a_soft_vector: assert property (p_soft_vector) else $error("reset vector missed");

  property p_ovf_set;
    stkOvfEv |=> stkOvfFf;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_unf_set;
    stkUnfEv |=> stkUnfFf;
  endproperty
  a_unf_set: assert property (p_unf_set) else $error("underflow flag not set");

  property p_stk_reset;
    (stkOvfEv || stkUnfEv) |=> softRstFf == $past(stkResetEn);
  endproperty
  a_stk_reset: assert property (p_stk_reset) else $error("stack reset gating wrong");

  property p_flag_hold;
    stkOvfFf && !stkFlagClr ##1 softRstFf |-> stkOvfFf;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost on reset");

  property p_prog_latency;
    takeReq && !fileWe && mapProg |=> !fileAck [*3] ##1 fileAck;
  endproperty
  a_prog_latency: assert property (p_prog_latency) else $error("prog read latency");

  property p_data_latency;
    takeReq && !fileWe && !mapProg && !mapCore |=> !fileAck [*2] ##1 fileAck;
  endproperty
  a_data_latency: assert property (p_data_latency) else $error("data read latency");

  property p_prog_low8;
    stateFf == ST_CAPT && reqProgFf && !softRstFf |=> fileRdata == $past(progLow);
  endproperty
  a_prog_low8: assert property (p_prog_low8) else $error("prog byte wrong");

  property p_no_prog_write;
    takeReq && fileWe && mapProg |=> fileAck && !dmem.we && !progRe;
  endproperty
  a_no_prog_write: assert property (p_no_prog_write) else $error("prog write leaked");

  property p_unimpl_zero;
    stateFf == ST_CAPT && reqUnimplFf && !softRstFf |=> fileRdata == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimpl not zero");

  property p_bank_direct;
    takeReq && !isIndf && !mapCore && fileAddr < COMMON_BASE
      |=> dmem.addr == {$past(bankFf), $past(fileAddr)};
  endproperty
  a_bank_direct: assert property (p_bank_direct) else $error("bank select ignored");

  property p_restore;
    restore && !softRstFf |=> wregFf == $past(shadowWreg) && bankFf == $past(shadowBank);
  endproperty
  a_restore: assert property (p_restore) else $error("context not restored");

  c_irq_return: cover property (irqAccept ##[1:20] restore);
  c_prog_read: cover property (progRe ##3 fileAck);
  c_overflow_reset: cover property (stkOvfEv ##1 softRstFf);
  c_linear_read: cover property (takeReq && isIndf && selPtr[15:13] == 3'b001);
endmodule

// File: cma_mem_model.sv
`timescale 1ns/100ps
module cma_mem_model
  import cma_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // program flash
  input wire logic [PROG_AW-1:0] progAddr,
  input wire logic progRe,
  output logic [PROG_DW-1:0] progRdata,
  // data ram
  input wire cma_dmem_t dmem,
  output logic [7:0] dmemRdata
);
  // ----
  // storage
  // ----
  // 32 banks of 128 bytes behind a 12-bit address
  logic [7:0] ram [0:4095];
  initial progRdata = 14'h0000;
  initial dmemRdata = 8'h00;
  // read-only flash, word held until the next strobe
  always @(posedge clk_sys)
  begin
    if (progRe)
      progRdata <= {progAddr[1:0], progAddr ^ 12'h05A3};
  end
  // sync ram, read data scrambled once its cycle is over
  always @(posedge clk_sys)
  begin
    if (dmem.we)
      ram[dmem.addr] <= dmem.wdata;
    dmemRdata <= dmem.re ? ram[dmem.addr] : ~dmemRdata;
  end
endmodule

// File: cma_core_tb.sv
`timescale 1ns/100ps
module cma_core_tb
  import cma_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic stkResetEn = 1'b1;
  logic stkFlagClr = 1'b0;
  cma_op_t op = OP_NONE;
  logic [10:0] opLit = 11'h000;
  logic irqAccept = 1'b0;
  logic fileReq = 1'b0;
  logic fileWe = 1'b0;
  logic [6:0] fileAddr = 7'h00;
  logic [7:0] fileWdata = 8'h00;
  logic fileReady, fileAck, progRe, stkOvfFlag, stkUnfFlag, softResetReq;
  logic [7:0] fileRdata, dmemRdata, wregOut, statusOut, q, d;
  logic [PROG_AW-1:0] fetchAddr, progAddr;
  logic [PROG_DW-1:0] progRdata;
  cma_dmem_t dmem;
  logic [PC_W-1:0] pcOut, pc0;
  logic [4:0] bankOut, stackDepth, b;
  logic [6:0] o;
  logic [15:0] p;
  int lat, n, fail_count = 0, checks_done = 0;
  // design and memories
  cma_core DUT (.clk_sys, .reset, .stkResetEn, .stkFlagClr, .op, .opLit, .irqAccept,
    .fileReq, .fileWe, .fileAddr, .fileWdata, .fileReady, .fileAck, .fileRdata, .fetchAddr,
    .progAddr, .progRe, .progRdata, .dmem, .dmemRdata, .pcOut, .wregOut, .statusOut,
    .bankOut, .stkOvfFlag, .stkUnfFlag, .softResetReq, .stackDepth);
  cma_mem_model MEM (.clk_sys, .progAddr, .progRe, .progRdata, .dmem, .dmemRdata);
  always #2 clk_sys = ~clk_sys;
  // ----
  // helpers
  // ----
  function automatic logic [11:0] lin(input int k);
    return {5'(k / 80), 7'(32 + k % 80)};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one file port transfer, entered at a falling edge
  task automatic acc(input logic we, input logic [6:0] a, input logic [7:0] wd);
    fileReq = 1'b1;
    fileWe = we;
    fileAddr = a;
    fileWdata = wd;
    lat = 0;
    while (fileReady !== 1'b1 && lat < 20)
    begin
      @(negedge clk_sys);
      lat++;
    end
    if (lat >= 20)
    begin
      fail_count++;
      results();
    end
    @(negedge clk_sys);
    fileReq = 1'b0;
    lat = 1;
    while (fileAck !== 1'b1 && lat < 20)
    begin
      @(negedge clk_sys);
      lat++;
    end
    q = fileRdata;
    if (lat >= 20)
    begin
      fail_count++;
      results();
    end
  endtask
  task automatic setp(input logic [6:0] a, input logic [15:0] v);
    acc(1'b1, a, v[7:0]);
    acc(1'b1, a + 7'h01, v[15:8]);
  endtask
  task automatic step(input cma_op_t o2, input logic irq);
    op = o2;
    irqAccept = irq;
    @(negedge clk_sys);
    op = OP_NONE;
    irqAccept = 1'b0;
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    void'($urandom(32'h5457_2cf2));
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    chk("pc", 16'(RESET_VEC), 16'(pcOut));
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      n = (i == 0) ? 0 : (i == 1) ? 2559 : $urandom % 2560;
      {b, o} = lin(n);
      d = 8'($urandom);
      acc(1'b1, OFF_BANK, {3'($urandom), b});
      chk("bankOut", 16'(b), 16'(bankOut));
      acc(1'b0, OFF_BANK, 8'h00);
      chk("bank", 16'(b), 16'(q));
      chk("core lat", 16'h0001, 16'(lat));
      acc(1'b1, o, d);
      chk("ram", 16'(d), 16'(MEM.ram[{b, o}]));
      p = 16'h2000 + 16'(n);
      setp(OFF_PTR0L, p);
      acc(1'b0, OFF_INDIRECT_DATA_0, 8'h00);
      chk("linear", 16'(d), 16'(q));
      acc(1'b0, o, 8'h00);
      chk("direct", 16'(d), 16'(q));
      chk("ram lat", 16'h0003, 16'(lat));
    end
    $display("test banked done");
    setp(OFF_PTR0L, 16'h1000 | 16'($urandom % 4096));
    acc(1'b0, OFF_INDIRECT_DATA_0, 8'h00);
    chk("unimpl", 16'h0000, 16'(q));
    p = 16'h8000 | 16'($urandom);
    setp(OFF_PTR1L, p);
    acc(1'b0, OFF_PTR1H, 8'h00);
    chk("ptr1 high", 16'(p[15:8]), 16'(q));
    acc(1'b0, OFF_INDIRECT_DATA_1, 8'h00);
    chk("prog", 16'(p[7:0] ^ 8'hA3), 16'(q));
    chk("prog lat", 16'h0004, 16'(lat));
    acc(1'b1, OFF_INDIRECT_DATA_1, ~q);
    chk("prog wr lat", 16'h0001, 16'(lat));
    acc(1'b0, OFF_INDIRECT_DATA_1, 8'h00);
    chk("prog kept", 16'(p[7:0] ^ 8'hA3), 16'(q));
    $display("test program done");
    acc(1'b1, OFF_PROG_COUNTER_LATCH_HIGH, 8'h78);
    opLit = 11'($urandom);
    step(OP_GOTO, 1'b0);
    chk("pc goto", {5'h0F, opLit}, 16'(pcOut));
    chk("fetch", {4'h0, 1'b1, opLit}, 16'(fetchAddr));
    pc0 = pcOut;
    d = 8'($urandom);
    acc(1'b1, OFF_WORKING_REG, d);
    step(OP_NONE, 1'b1);
    chk("pc irq", 16'(IRQ_VEC), 16'(pcOut));
    chk("depth", 16'h0001, 16'(stackDepth));
    acc(1'b1, OFF_WORKING_REG, ~d);
    step(OP_RETFIE, 1'b0);
    chk("pc ret", 16'(pc0), 16'(pcOut));
    chk("working_reg", 16'(d), 16'(wregOut));
    d = 8'($urandom);
    acc(1'b1, OFF_STATUS, d);
    chk("statusOut", 16'(d), 16'(statusOut));
    pc0 = pcOut;
    step(OP_CALL, 1'b0);
    step(OP_RETURN, 1'b0);
    chk("pc return", 16'(15'(pc0 + 15'h0001)), 16'(pcOut));
    pc0 = pcOut;
    step(OP_NEXT, 1'b0);
    chk("pc next", 16'(15'(pc0 + 15'h0001)), 16'(pcOut));
    d = 8'($urandom);
    acc(1'b1, OFF_WORKING_REG, d);
    pc0 = pcOut;
    step(OP_BRW, 1'b0);
    chk("pc brw", 16'(15'(pc0 + 15'h0001 + 15'(d))), 16'(pcOut));
    // common bytes fold onto bank 0 from any bank
    o = 7'h70 | 7'($urandom % 16);
    d = 8'($urandom);
    acc(1'b1, OFF_BANK, 8'h1F);
    acc(1'b1, o, d);
    chk("common", 16'(d), 16'(MEM.ram[{5'h00, o}]));
    $display("test interrupt done");
    repeat (16) step(OP_CALL, 1'b0);
    chk("depth", 16'h0010, 16'(stackDepth));
    step(OP_CALL, 1'b0);
    chk("ovf", 16'h0001, 16'(stkOvfFlag));
    chk("soft", 16'h0001, 16'(softResetReq));
    @(negedge clk_sys);
    chk("pc soft", 16'h0000, 16'(pcOut));
    chk("ovf kept", 16'h0001, 16'(stkOvfFlag));
    stkResetEn = 1'b0;
    step(OP_RETURN, 1'b0);
    chk("unf", 16'h0001, 16'(stkUnfFlag));
    chk("no soft", 16'h0000, 16'(softResetReq));
    stkFlagClr = 1'b1;
    @(negedge clk_sys);
    stkFlagClr = 1'b0;
    @(negedge clk_sys);
    chk("flags clr", 16'h0000, 16'({stkOvfFlag, stkUnfFlag}));
    $display("test stack done");
    results();
  end
endmodule
